// file: obcm_regs.vh
// Constants of the option byte clock and flash mode loader
`ifndef OBCM_REGS_VH
`define OBCM_REGS_VH

// ***************
// Option byte
// ***************
`define OBCM_OPT_ADDR_PRI   17'h000c2
`define OBCM_OPT_ADDR_ALT   17'h010c2
`define OBCM_MODE_HI_BIT    7
`define OBCM_MODE_LO_BIT    6
`define OBCM_FIX1_BIT       5
`define OBCM_FIX0_BIT       4
`define OBCM_FRQ_MSB        3
`define OBCM_MODE_LV        2'b00
`define OBCM_MODE_LS        2'b10
`define OBCM_MODE_HS        2'b11

// ***************
// APB register map
// ***************
`define OBCM_REG_STATUS     12'h000
`define OBCM_REG_RAW        12'h004
`define OBCM_REG_FREQ       12'h008
`define OBCM_REG_MODE       12'h00c
`define OBCM_REG_CTRL       12'h010
`define OBCM_CTRL_RESET     1'b1

`endif

// file: obcm_decode.v
// Combinational decode of the option byte fields
`timescale 1ns/1ns
`include "obcm_regs.vh"
module obcm_decode (
   input  wire [7:0] opt_byte,
   input  wire       osc_freq_select_b4,
   output reg  [2:0] mode_onehot,
   output reg        mode_bad,
   output reg  [6:0] oscillator_frequency,
   output reg  [5:0] main_clock_frequency,
   output reg        freq_bad,
   output wire       fixed_bad
);

   wire [1:0] mode_sel;
   wire [4:0] freq_sel;

   assign mode_sel  = {opt_byte[`OBCM_MODE_HI_BIT], opt_byte[`OBCM_MODE_LO_BIT]};
   assign freq_sel  = {osc_freq_select_b4, opt_byte[`OBCM_FRQ_MSB:0]};
   assign fixed_bad = ~opt_byte[`OBCM_FIX1_BIT] | opt_byte[`OBCM_FIX0_BIT];

   // Mode one-hot order: {high speed, low speed, low voltage}
   always @* begin
      mode_bad = 1'b0;
      case (mode_sel)
         `OBCM_MODE_LV: mode_onehot = 3'h1;
         `OBCM_MODE_LS: mode_onehot = 3'h2;
         `OBCM_MODE_HS: mode_onehot = 3'h4;
         default: begin
            mode_onehot = 3'h0;
            mode_bad    = 1'b1;
         end
      endcase
   end

   always @* begin
      freq_bad = 1'b0;
      case (freq_sel)
         5'h18: begin oscillator_frequency = 7'd64; main_clock_frequency = 6'd32; end
         5'h10: begin oscillator_frequency = 7'd48; main_clock_frequency = 6'd24; end
         5'h08: begin oscillator_frequency = 7'd32; main_clock_frequency = 6'd32; end
         5'h00: begin oscillator_frequency = 7'd24; main_clock_frequency = 6'd24; end
         5'h09: begin oscillator_frequency = 7'd16; main_clock_frequency = 6'd16; end
         5'h01: begin oscillator_frequency = 7'd12; main_clock_frequency = 6'd12; end
         5'h0a: begin oscillator_frequency = 7'd8;  main_clock_frequency = 6'd8;  end
         5'h02: begin oscillator_frequency = 7'd6;  main_clock_frequency = 6'd6;  end
         5'h0b: begin oscillator_frequency = 7'd4;  main_clock_frequency = 6'd4;  end
         5'h03: begin oscillator_frequency = 7'd3;  main_clock_frequency = 6'd3;  end
         5'h0c: begin oscillator_frequency = 7'd2;  main_clock_frequency = 6'd2;  end
         5'h0d: begin oscillator_frequency = 7'd1;  main_clock_frequency = 6'd1;  end
         default: begin
            oscillator_frequency = 7'd0;
            main_clock_frequency = 6'd0;
            freq_bad             = 1'b1;
         end
      endcase
   end

endmodule // obcm_decode

// file: obcm_top.v
// Option byte loader: fetch after reset, decode, hold, APB status view
//
// Chosen here: the APB slave port.
`timescale 1ns/1ns
`include "obcm_regs.vh"
module obcm_top (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        boot_swap,
   input  wire        osc_freq_select_b4,
   output reg         nvm_rd_req,
   output reg  [16:0] nvm_rd_addr,
   input  wire [7:0]  nvm_rd_data,
   input  wire        nvm_rd_valid,
   output reg         config_valid,
   output reg         config_error,
   output reg         low_voltage_main_mode,
   output reg         low_speed_main_mode,
   output reg         high_speed_main_mode,
   output reg  [6:0]  oscillator_frequency,
   output reg  [5:0]  main_clock_frequency
);

   // ***************
   // Loader states
   // ***************
   localparam [2:0] ST_FETCH = 3'b001;
   localparam [2:0] ST_WAIT  = 3'b010;
   localparam [2:0] ST_DONE  = 3'b100;

   reg  [2:0]  state;
   reg  [2:0]  next_state;
   reg  [7:0]  opt_byte;
   reg         freq_b4;
   reg         swap_used;
   reg         fallback_en;

   wire [2:0]  dec_mode;
   wire        dec_mode_bad;
   wire [6:0]  dec_osc;
   wire [5:0]  dec_main;
   wire        dec_freq_bad;
   wire        dec_fixed_bad;
   wire        any_bad;
   wire        loaded;
   wire        apb_access;
   wire        addr_ok;
   reg  [31:0] next_prdata;

   obcm_decode u_decode (
      .opt_byte             (opt_byte),
      .osc_freq_select_b4   (freq_b4),
      .mode_onehot          (dec_mode),
      .mode_bad             (dec_mode_bad),
      .oscillator_frequency (dec_osc),
      .main_clock_frequency (dec_main),
      .freq_bad             (dec_freq_bad),
      .fixed_bad            (dec_fixed_bad)
   );

   assign any_bad = dec_mode_bad | dec_freq_bad | dec_fixed_bad;
   assign loaded  = (state == ST_DONE);

   // ***************
   // Loader state machine
   // ***************
   always @* begin
      case (state)
         ST_FETCH: next_state = ST_WAIT;
         ST_WAIT:  next_state = nvm_rd_valid ? ST_DONE : ST_WAIT;
         ST_DONE:  next_state = ST_DONE;
         default:  next_state = ST_FETCH;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state       <= ST_FETCH;
         nvm_rd_req  <= 1'b0;
         nvm_rd_addr <= 17'h00000;
         swap_used   <= 1'b0;
      end else begin
         state <= next_state;
         if (state == ST_FETCH) begin
            nvm_rd_req  <= 1'b1;
            swap_used   <= boot_swap;
            nvm_rd_addr <= boot_swap ? `OBCM_OPT_ADDR_ALT : `OBCM_OPT_ADDR_PRI;
         end else if (state == ST_WAIT && nvm_rd_valid) begin
            nvm_rd_req  <= 1'b0;
         end
      end
   end

   // Byte and b4 captured once, only on the single fetch answer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opt_byte <= 8'h00;
         freq_b4  <= 1'b0;
      end else if (state == ST_WAIT && nvm_rd_valid) begin
         opt_byte <= nvm_rd_data;
         freq_b4  <= osc_freq_select_b4;
      end
   end

   // ***************
   // Settings outputs
   // ***************
   // Bad byte with fallback on: slowest safe setting, low-voltage at 1 MHz
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         config_valid          <= 1'b0;
         config_error          <= 1'b0;
         low_voltage_main_mode <= 1'b0;
         low_speed_main_mode   <= 1'b0;
         high_speed_main_mode  <= 1'b0;
         oscillator_frequency  <= 7'd0;
         main_clock_frequency  <= 6'd0;
      end else if (loaded && !config_valid) begin
         // Latched on the first loaded cycle only; later fallback writes do not move them
         config_valid <= 1'b1;
         config_error <= any_bad;
         if (any_bad && fallback_en) begin
            low_voltage_main_mode <= 1'b1;
            low_speed_main_mode   <= 1'b0;
            high_speed_main_mode  <= 1'b0;
            oscillator_frequency  <= 7'd1;
            main_clock_frequency  <= 6'd1;
         end else begin
            low_voltage_main_mode <= dec_mode[0];
            low_speed_main_mode   <= dec_mode[1];
            high_speed_main_mode  <= dec_mode[2];
            oscillator_frequency  <= dec_osc;
            main_clock_frequency  <= dec_main;
         end
      end
   end

   // ***************
   // APB slave, zero wait states
   // ***************
   assign apb_access = psel & penable;
   assign addr_ok    = (paddr == `OBCM_REG_STATUS) | (paddr == `OBCM_REG_RAW) |
                       (paddr == `OBCM_REG_FREQ)   | (paddr == `OBCM_REG_MODE) |
                       (paddr == `OBCM_REG_CTRL);

   always @* begin
      next_prdata = 32'h00000000;
      case (paddr)
         `OBCM_REG_STATUS: next_prdata = {26'h0, swap_used, dec_fixed_bad & loaded,
                                          dec_freq_bad & loaded, dec_mode_bad & loaded, any_bad & loaded, loaded};
         `OBCM_REG_RAW:    next_prdata = {23'h0, freq_b4, opt_byte};
         `OBCM_REG_FREQ:   next_prdata = {18'h0, main_clock_frequency, 1'b0, oscillator_frequency};
         `OBCM_REG_MODE:   next_prdata = {29'h0, high_speed_main_mode, low_speed_main_mode, low_voltage_main_mode};
         `OBCM_REG_CTRL:   next_prdata = {31'h0, fallback_en};
         default:          next_prdata = 32'h00000000;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata      <= 32'h00000000;
         pready      <= 1'b0;
         pslverr     <= 1'b0;
         fallback_en <= `OBCM_CTRL_RESET;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~addr_ok;
         prdata  <= (psel & ~penable & ~pwrite) ? next_prdata : 32'h00000000;
         if (apb_access && pready && pwrite && paddr == `OBCM_REG_CTRL)
            fallback_en <= pwdata[0];
      end
   end

endmodule // obcm_top

// file: obcm_top_sva.sv
// Assertions on the ports of the option byte loader
`timescale 1ns/1ns
module obcm_top_sva (
   input logic        pclk,
   input logic        presetn,
   input logic        boot_swap,
   input logic        osc_freq_select_b4,
   input logic        nvm_rd_req,
   input logic [16:0] nvm_rd_addr,
   input logic [7:0]  nvm_rd_data,
   input logic        nvm_rd_valid,
   input logic        config_valid,
   input logic        config_error,
   input logic        low_voltage_main_mode,
   input logic        low_speed_main_mode,
   input logic        high_speed_main_mode,
   input logic [6:0]  oscillator_frequency,
   input logic [5:0]  main_clock_frequency
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Byte capture from the store
   sequence s_take;
      nvm_rd_req && nvm_rd_valid;
   endsequence
   sequence s_loaded;
      !nvm_rd_req ##1 config_valid;
   endsequence
   a_fetch_addr: assert property ($rose(nvm_rd_req) |-> nvm_rd_addr == ($past(boot_swap) ? 17'h010c2 : 17'h000c2))
      else $error("fetch address wrong");
   a_take_load: assert property (s_take |=> s_loaded)
      else $error("capture did not load settings");
   a_mode_onehot: assert property (config_valid && !config_error |-> $onehot({high_speed_main_mode, low_speed_main_mode,
      low_voltage_main_mode}))
      else $error("mode outputs not one-hot");
   a_bad_mode: assert property (s_take and nvm_rd_data[7:6] == 2'b01
      |-> ##2 config_error && !high_speed_main_mode && !low_speed_main_mode)
      else $error("prohibited mode not flagged");
   a_bad_fixed: assert property (s_take and nvm_rd_data[5:4] != 2'b10 |-> ##2 config_error)
      else $error("fixed bits not flagged");
   a_freq_top: assert property (s_take and osc_freq_select_b4 && nvm_rd_data == 8'he8
      |-> ##2 oscillator_frequency == 7'h40 && main_clock_frequency == 6'h20)
      else $error("top frequency code wrong");
   a_valid_kept: assert property (config_valid |=> config_valid && !nvm_rd_req)
      else $error("load not kept");
   a_hold_vals: assert property (config_valid && $past(config_valid)
      |-> $stable({oscillator_frequency, main_clock_frequency, config_error}))
      else $error("settings changed after load");
   a_zero_early: assert property (!config_valid |-> oscillator_frequency == 7'h00 && main_clock_frequency == 6'h00)
      else $error("frequency shown before load");
endmodule // obcm_top_sva

bind obcm_top obcm_top_sva i_obcm_top_sva (.pclk(pclk), .presetn(presetn), .boot_swap(boot_swap),
   .osc_freq_select_b4(osc_freq_select_b4), .nvm_rd_req(nvm_rd_req), .nvm_rd_addr(nvm_rd_addr),
   .nvm_rd_data(nvm_rd_data), .nvm_rd_valid(nvm_rd_valid), .config_valid(config_valid), .config_error(config_error),
   .low_voltage_main_mode(low_voltage_main_mode), .low_speed_main_mode(low_speed_main_mode),
   .high_speed_main_mode(high_speed_main_mode), .oscillator_frequency(oscillator_frequency),
   .main_clock_frequency(main_clock_frequency));

// file: option_byte_clock_mode_decode_bench.sv
// Self-checking bench of the option byte loader
`timescale 1ns/1ns
module option_byte_clock_mode_decode_bench;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        boot_swap = 1'b0, osc_freq_select_b4 = 1'b0, nvm_rd_valid = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [7:0]  nvm_rd_data = 8'h00;
   logic        pready, pslverr, nvm_rd_req, config_valid, config_error;
   logic        low_voltage_main_mode, low_speed_main_mode, high_speed_main_mode;
   logic [16:0] nvm_rd_addr;
   logic [6:0]  oscillator_frequency;
   logic [5:0]  main_clock_frequency;
   int          failures = 0, check_count = 0;
   localparam logic [4:0]  FCODE [12] = '{5'h18, 5'h10, 5'h08, 5'h00, 5'h09, 5'h01, 5'h0a, 5'h02, 5'h0b, 5'h03,
      5'h0c, 5'h0d};
   // Oscillator MHz in the upper seven bits, main clock MHz in the lower six
   localparam logic [12:0] FEXP [12] = '{13'h1020, 13'h0c18, 13'h0820, 13'h0618, 13'h0410, 13'h030c, 13'h0208,
      13'h0186, 13'h0104, 13'h00c3, 13'h0082, 13'h0041};
   localparam logic [8:0]  BAD [3] = '{9'h068, 9'h0c8, 9'h1ef};

   obcm_top i_obcm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .boot_swap(boot_swap),
      .osc_freq_select_b4(osc_freq_select_b4), .nvm_rd_req(nvm_rd_req), .nvm_rd_addr(nvm_rd_addr),
      .nvm_rd_data(nvm_rd_data), .nvm_rd_valid(nvm_rd_valid), .config_valid(config_valid),
      .config_error(config_error), .low_voltage_main_mode(low_voltage_main_mode),
      .low_speed_main_mode(low_speed_main_mode), .high_speed_main_mode(high_speed_main_mode),
      .oscillator_frequency(oscillator_frequency), .main_clock_frequency(main_clock_frequency));

   always #5 pclk = ~pclk;

   function logic [16:0] cfg();
      return {config_error, high_speed_main_mode, low_speed_main_mode, low_voltage_main_mode,
         oscillator_frequency, main_clock_frequency};
   endfunction

   task chk_val(input logic [32:0] g, input logic [32:0] e);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask

   // One APB transfer; returns at the edge that samples pready
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task rd(input logic [11:0] a, input logic [32:0] e);
      apb(1'b0, a, 32'h0);
      chk_val({pslverr, prdata}, e);
   endtask

   // Reset, serve the one fetch, wait for the settings
   task load(input logic [7:0] b, input logic b4, input logic sw, input logic fb);
      presetn <= 1'b0;
      boot_swap <= sw;
      osc_freq_select_b4 <= b4;
      nvm_rd_data <= b;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      while (nvm_rd_req !== 1'b1) @(posedge pclk);
      chk_val(nvm_rd_addr, sw ? 17'h010c2 : 17'h000c2);
      // Fallback off must be written before the byte arrives
      if (!fb)
         apb(1'b1, 12'h010, 32'h0);
      nvm_rd_valid <= 1'b1;
      @(posedge pclk);
      nvm_rd_valid <= 1'b0;
      while (config_valid !== 1'b1) @(posedge pclk);
   endtask

   task t_freq;
      for (int i = 0; i < 12; i++) begin
         load({4'he, FCODE[i][3:0]}, FCODE[i][4], 1'b0, 1'b1);
         chk_val(cfg(), {1'b0, 3'b100, FEXP[i]});
      end
   endtask

   task t_mode;
      for (int i = 0; i < 3; i++) begin
         load({i > 0, i > 1, 6'h2d}, 1'b0, 1'b0, 1'b1);
         chk_val(cfg(), {1'b0, 3'b001 << i, 13'h0041});
      end
   endtask

   task t_bad;
      for (int i = 0; i < 3; i++) begin
         load(BAD[i][7:0], BAD[i][8], 1'b0, 1'b1);
         chk_val(cfg(), {1'b1, 3'b001, 13'h0041});
      end
   endtask

   task t_hold;
      load(8'he8, 1'b0, 1'b1, 1'b1);
      nvm_rd_data <= 8'h00;
      nvm_rd_valid <= 1'b1;
      @(posedge pclk);
      nvm_rd_valid <= 1'b0;
      repeat (3) @(posedge pclk);
      chk_val(cfg(), {1'b0, 3'b100, 13'h0820});
      rd(12'h000, 33'h21);
      rd(12'h004, 33'h0e8);
      rd(12'h008, 33'h2020);
      rd(12'h00c, 33'h4);
      rd(12'h010, 33'h1);
      apb(1'b1, 12'h010, 32'h0);
      rd(12'h010, 33'h0);
      apb(1'b1, 12'h000, 32'hffff);
      rd(12'h000, 33'h21);
      rd(12'h020, 33'h100000000);
      chk_val(cfg(), {1'b0, 3'b100, 13'h0820});
   endtask

   // Prohibited mode with fallback off, then a late fallback write that must not move the settings
   task t_nofb;
      load(BAD[0][7:0], BAD[0][8], 1'b0, 1'b0);
      chk_val(cfg(), {1'b1, 3'b000, 13'h0820});
      rd(12'h000, 33'h07);
      apb(1'b1, 12'h010, 32'h1);
      repeat (2) @(posedge pclk);
      chk_val(cfg(), {1'b1, 3'b000, 13'h0820});
   endtask

   task complete_run;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial begin
      t_freq;
      t_mode;
      t_bad;
      t_nofb;
      t_hold;
      complete_run;
   end

   initial begin
      #100000;
      failures++;
      complete_run;
   end
endmodule // option_byte_clock_mode_decode_bench
